// ===== hdl/srdp_pkg.sv
// constants, types and register map of the serial register datagram port
package srdp_pkg;
   // frame layout
   localparam int            FRAME_BITS   = 40;
   localparam int            DATA_BITS    = 32;
   localparam logic [5:0]    FRAME_CNT    = 6'h28;
   localparam logic [7:0]    WRITE_FLAG   = 8'h80;
   localparam int            WR_BIT       = 39;
   // link status byte positions and their sources
   localparam int            ST_STOP2     = 6;
   localparam int            ST_STOP1     = 5;
   localparam int            ST_VREACH2   = 4;
   localparam int            ST_VREACH1   = 3;
   localparam int            PROF_STOP    = 0;
   localparam int            PROF_VREACH  = 8;
   // global state register: address and value after reset (reset seen)
   localparam logic [6:0]    GSTATE_ADDR  = 7'h01;
   localparam logic [2:0]    GSTATE_RST   = 3'h1;
   // timing: link clock made by the controller from the system clock
   localparam int            CLK_PERIOD_NS = 100;
   localparam int            SCK_PERIOD_NS = 800;
   localparam int            HALF_CYC_I    =
      SCK_PERIOD_NS / (2 * CLK_PERIOD_NS);
   localparam logic [7:0]    SCK_HALF_CYC  = 8'(HALF_CYC_I);
   localparam logic [7:0]    CS_GAP_CYC    = 8'(2 * HALF_CYC_I);
   // controller register offsets (byte addresses)
   localparam logic [4:0]    OFS_CMD_ADDR  = 5'h00;
   localparam logic [4:0]    OFS_CMD_DATA  = 5'h04;
   localparam logic [4:0]    OFS_CTRL      = 5'h08;
   localparam logic [4:0]    OFS_RSP_STAT  = 5'h0C;
   localparam logic [4:0]    OFS_RSP_DATA  = 5'h10;
   localparam int            CTRL_START    = 0;
   localparam int            CTRL_WRITE    = 1;

   typedef enum logic [2:0] {
      H_IDLE, H_LEAD, H_LOW, H_HIGH, H_TRAIL, H_GAP
   } srdp_hst_state_t;

   typedef struct packed {
      logic [39:0] sr;
      logic        sdo;
      logic [5:0]  cnt;
      logic        sck_d;
      logic        cs_d;
      logic [2:0]  gstate;
      logic [31:0] resp;
      logic        rd_pend;
      logic [6:0]  addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } srdp_dev_st_t;

   typedef struct packed {
      srdp_hst_state_t st;
      logic [7:0]      cnt;
      logic [5:0]      idx;
      logic [39:0]     tx;
      logic [39:0]     rx;
      logic            sck;
      logic            sdi;
      logic            cs_n;
      logic [6:0]      cmd_addr;
      logic [31:0]     cmd_data;
      logic            waitreq;
      logic [31:0]     rdata;
   } srdp_hst_st_t;
endpackage

// ===== hdl/srdp_link_if.sv
// serial link between controller and device
`timescale 1ns/1ps
interface srdp_link_if;
   logic sck;
   logic sdi;
   logic sdo;
   logic frame_select_n;

   modport dev  (input sck, input sdi, input frame_select_n, output sdo);
   modport host (output sck, output sdi, output frame_select_n, input sdo);
endinterface

// ===== hdl/srdp_sync.sv
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module srdp_sync #(
   parameter int             W   = 1,
   parameter logic [W-1:0]   RST = '0
) (
   input  wire logic         CLK,
   input  wire logic         RESET,
   input  wire logic [W-1:0] D,
   output      logic [W-1:0] Q
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } srdp_sync_st_t;

   srdp_sync_st_t st_r;
   srdp_sync_st_t st_nxt;

   // first stage feeds only the second stage
   always_comb begin
      st_nxt    = st_r;
      st_nxt.s1 = D;
      st_nxt.s2 = st_r.s1;
   end

   always_ff @(posedge CLK) begin
      if (RESET) begin
         st_r <= '{s1: RST, s2: RST};
      end else begin
         st_r <= st_nxt;
      end
   end

   assign Q = st_r.s2;
endmodule

// ===== hdl/srdp_device.sv
// device end: 40-bit serial register port with pipelined read back
//
// Overview of operation
// - frame is address byte plus four data bytes
// - master keeps select low for whole frame
// - most significant bit first, both directions
// - every register moves as 32-bit word
// - bit 39 set writes, clear reads
// - master adds 0x80 to address for writes
// - response shifted out on every frame
// - after read, next frame returns register contents
// - after write, next frame echoes write data
// - read leaves register untouched except state flags, data ignored
// - master pipelines reads, one extra frame last
// - top response byte is link status
// - bit7 zero, bits6/5 left stop switches
// - bits4/3 target velocity reached per axis
// - bits2/1 driver errors, cleared by state read
// - bit0 reset seen, cleared by state read
// - narrow values right aligned, two's complement
// - sample on rising, drive after falling edge
// - select release acts on last 40 bits
// - excess bits reappear forty clocks later
`timescale 1ns/1ps
module srdp_device
   import srdp_pkg::*;
(
   input  wire logic        CLK,
   input  wire logic        RESET,
   srdp_link_if.dev         LINK,
   input  wire logic [31:0] AXIS1_PROFILE_STATE,
   input  wire logic [31:0] AXIS2_PROFILE_STATE,
   input  wire logic [1:0]  DRV_ERR_SET,
   input  wire logic [31:0] REG_RDATA,
   output      logic [6:0]  REG_ADDR,
   output      logic [31:0] REG_WDATA,
   output      logic        REG_WR,
   output      logic        REG_RD,
   output      logic [7:0]  LINK_STATUS
);
   import srdp_pkg::*;

   srdp_dev_st_t st_r;
   srdp_dev_st_t st_nxt;
   logic [2:0]   pins_s;
   logic         cs_s;
   logic         sck_s;
   logic         sdi_s;
   logic [7:0]   status_now;
   logic [39:0]  cmd;

   ////////////////////////////////////////////////////////////////////////
   // pin synchronisers; master must keep the link clock below half CLK
   srdp_sync #(
      .W   (3),
      .RST (3'h6)
   ) u_sync (
      .CLK   (CLK),
      .RESET (RESET),
      .D     ({LINK.frame_select_n, LINK.sck, LINK.sdi}),
      .Q     (pins_s)
   );

   assign cs_s  = pins_s[2];
   assign sck_s = pins_s[1];
   assign sdi_s = pins_s[0];
   assign cmd   = st_r.sr;

   ////////////////////////////////////////////////////////////////////////
   // link status byte, built fresh from the axis profile inputs and the global state
   always_comb begin
      status_now             = '0; // bit 7 stays zero
      status_now[ST_STOP2]   = AXIS2_PROFILE_STATE[PROF_STOP];
      status_now[ST_STOP1]   = AXIS1_PROFILE_STATE[PROF_STOP];
      status_now[ST_VREACH2] = AXIS2_PROFILE_STATE[PROF_VREACH];
      status_now[ST_VREACH1] = AXIS1_PROFILE_STATE[PROF_VREACH];
      status_now[2:0]        = st_r.gstate;
   end

   ////////////////////////////////////////////////////////////////////////
   // frame engine: one shift register both receives and transmits, so
   // bits past the fortieth fall out of the top forty clocks later
   always_comb begin
      st_nxt       = st_r;
      st_nxt.wr    = 1'b0;
      st_nxt.rd    = 1'b0;
      st_nxt.sck_d = sck_s;
      st_nxt.cs_d  = cs_s;

      if (!cs_s && st_r.cs_d) begin
         // select fell: stage status and last result ahead of bit 39
         st_nxt.sr  = {status_now, st_r.resp};
         st_nxt.sdo = status_now[7];
         st_nxt.cnt = '0;
      end else if (!cs_s) begin
         // only framed edges count; a clock outside a frame is ignored
         if (sck_s && !st_r.sck_d) begin
            st_nxt.sr = {st_r.sr[38:0], sdi_s};
            if (st_r.cnt != FRAME_CNT) begin
               st_nxt.cnt = st_r.cnt + 6'h01;
            end
         end
         if (!sck_s && st_r.sck_d) begin
            st_nxt.sdo = st_r.sr[39];
         end
      end

      // select rose: shift register holds the last forty bits received;
      // a short frame carries no whole command and is dropped
      if (cs_s && !st_r.cs_d && st_r.cnt == FRAME_CNT) begin
         if (cmd[WR_BIT]) begin
            st_nxt.addr  = cmd[38:32];
            st_nxt.wdata = cmd[31:0];
            st_nxt.wr    = 1'b1;
            st_nxt.resp  = cmd[31:0];
         end else if (cmd[38:32] == GSTATE_ADDR) begin
            // flags are read and cleared together, right aligned
            st_nxt.resp   = {29'h0000_0000, st_r.gstate};
            st_nxt.gstate = '0;
         end else begin
            // read: data bits of the request are discarded
            st_nxt.addr    = cmd[38:32];
            st_nxt.rd      = 1'b1;
            st_nxt.rd_pend = 1'b1;
         end
      end

      // register contents land one cycle after the read strobe
      if (st_r.rd_pend) begin
         st_nxt.resp    = REG_RDATA;
         st_nxt.rd_pend = 1'b0;
      end

      // a new driver error wins over a clear in the same cycle
      st_nxt.gstate[2:1] = st_nxt.gstate[2:1] | DRV_ERR_SET;
   end

   ////////////////////////////////////////////////////////////////////////
   // state register; reset leaves the reset-seen flag raised
   always_ff @(posedge CLK) begin
      if (RESET) begin
         st_r         <= '0;
         st_r.sck_d   <= 1'b1;
         st_r.cs_d    <= 1'b1;
         st_r.gstate  <= GSTATE_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // status mirror for local logic, registered like every other output
   logic [7:0] status_r;

   always_ff @(posedge CLK) begin
      if (RESET) begin
         status_r <= '0;
      end else begin
         status_r <= status_now;
      end
   end

   assign LINK.sdo    = st_r.sdo;
   assign REG_ADDR    = st_r.addr;
   assign REG_WDATA   = st_r.wdata;
   assign REG_WR      = st_r.wr;
   assign REG_RD      = st_r.rd;
   assign LINK_STATUS = status_r;
endmodule

// ===== hdl/srdp_host.sv
// controller end: Avalon-MM registers driving the serial link as master
`timescale 1ns/1ps
module srdp_host
   import srdp_pkg::*;
(
   input  wire logic        CLK,
   input  wire logic        RESET,
   srdp_link_if.host        LINK,
   input  wire logic [4:0]  AVS_ADDRESS,
   input  wire logic        AVS_READ,
   input  wire logic        AVS_WRITE,
   input  wire logic [31:0] AVS_WRITEDATA,
   output      logic [31:0] AVS_READDATA,
   output      logic        AVS_WAITREQUEST
);
   import srdp_pkg::*;

   srdp_hst_st_t st_r;
   srdp_hst_st_t st_nxt;
   logic         sdo_s;
   logic         busy;
   logic         req;
   logic         wr_take;

   srdp_sync #(
      .W   (1),
      .RST (1'b0)
   ) u_sync (
      .CLK   (CLK),
      .RESET (RESET),
      .D     (LINK.sdo),
      .Q     (sdo_s)
   );

   assign busy    = (st_r.st != H_IDLE);
   assign req     = AVS_READ || AVS_WRITE;
   assign wr_take = AVS_WRITE && !st_r.waitreq;

   ////////////////////////////////////////////////////////////////////////
   // bus slave: one wait cycle, then answer; data fixed while it waits
   always_comb begin
      st_nxt         = st_r;
      st_nxt.waitreq = !(req && st_r.waitreq);
      if (AVS_READ && st_r.waitreq) begin
         case (AVS_ADDRESS)
            OFS_CMD_ADDR: st_nxt.rdata = {25'h000_0000, st_r.cmd_addr};
            OFS_CMD_DATA: st_nxt.rdata = st_r.cmd_data;
            OFS_CTRL:     st_nxt.rdata = {31'h0000_0000, busy};
            OFS_RSP_STAT: st_nxt.rdata = {24'h00_0000, st_r.rx[39:32]};
            OFS_RSP_DATA: st_nxt.rdata = st_r.rx[31:0];
            default:      st_nxt.rdata = '0;
         endcase
      end
      // command registers freeze while a frame is on the wire
      if (wr_take && !busy) begin
         if (AVS_ADDRESS == OFS_CMD_ADDR) begin
            st_nxt.cmd_addr = AVS_WRITEDATA[6:0];
         end
         if (AVS_ADDRESS == OFS_CMD_DATA) begin
            st_nxt.cmd_data = AVS_WRITEDATA;
         end
      end

      //////////////////////////////////////////////////////////////////
      // frame sequencer; clock idles high, data changes on falling edge
      if (st_r.cnt != 8'h00) begin
         st_nxt.cnt = st_r.cnt - 8'h01;
      end
      case (st_r.st)
         H_IDLE: begin
            if (wr_take && AVS_ADDRESS == OFS_CTRL &&
                AVS_WRITEDATA[CTRL_START]) begin
               // write flag added to the plain address
               st_nxt.tx = {(AVS_WRITEDATA[CTRL_WRITE] ? WRITE_FLAG
                             : 8'h00) | {1'b0, st_r.cmd_addr},
                            st_r.cmd_data};
               st_nxt.cs_n = 1'b0;
               st_nxt.cnt  = SCK_HALF_CYC - 8'h01;
               st_nxt.st   = H_LEAD;
            end
         end
         H_LEAD: begin
            if (st_r.cnt == 8'h00) begin
               st_nxt.sck = 1'b0;
               st_nxt.sdi = st_r.tx[39];
               st_nxt.idx = 6'h27;
               st_nxt.cnt = SCK_HALF_CYC - 8'h01;
               st_nxt.st  = H_LOW;
            end
         end
         H_LOW: begin
            if (st_r.cnt == 8'h00) begin
               st_nxt.sck = 1'b1; // device samples here
               st_nxt.cnt = SCK_HALF_CYC - 8'h01;
               st_nxt.st  = H_HIGH;
            end
         end
         H_HIGH: begin
            if (st_r.cnt == 8'h00) begin
               // late sample covers the synchroniser delay on both ends
               st_nxt.rx  = {st_r.rx[38:0], sdo_s};
               st_nxt.cnt = SCK_HALF_CYC - 8'h01;
               if (st_r.idx == 6'h00) begin
                  st_nxt.st = H_TRAIL;
               end else begin
                  st_nxt.idx = st_r.idx - 6'h01;
                  st_nxt.sdi = st_r.tx[st_r.idx - 6'h01];
                  st_nxt.sck = 1'b0;
                  st_nxt.st  = H_LOW;
               end
            end
         end
         H_TRAIL: begin
            if (st_r.cnt == 8'h00) begin
               st_nxt.cs_n = 1'b1; // released only after bit 0
               st_nxt.cnt  = CS_GAP_CYC - 8'h01;
               st_nxt.st   = H_GAP;
            end
         end
         H_GAP: begin
            if (st_r.cnt == 8'h00) begin
               st_nxt.st = H_IDLE;
            end
         end
         default: begin
            st_nxt.st = H_IDLE;
         end
      endcase
   end

   always_ff @(posedge CLK) begin
      if (RESET) begin
         st_r         <= '0;
         st_r.st      <= H_IDLE;
         st_r.sck     <= 1'b1;
         st_r.cs_n    <= 1'b1;
         st_r.waitreq <= 1'b1;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign LINK.sck            = st_r.sck;
   assign LINK.sdi            = st_r.sdi;
   assign LINK.frame_select_n = st_r.cs_n;
   assign AVS_READDATA        = st_r.rdata;
   assign AVS_WAITREQUEST     = st_r.waitreq;
endmodule

// ===== tb/srdp_link_properties.sv
// concurrent checks on the serial link between controller and device
`timescale 1ns/1ps
module srdp_link_properties (
   input wire logic CLK,
   input wire logic RESET,
   input wire logic sck,
   input wire logic sdi,
   input wire logic sdo,
   input wire logic frame_select_n
);
   logic [6:0] rise_cnt_r;
   logic       sck_r;

   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (RESET);

   ////////////////////////////////////////////////////////////////////////
   // count link clock rises inside a frame; cleared while select is high
   always_ff @(posedge CLK) begin
      sck_r <= sck;
      if (RESET || frame_select_n) begin
         rise_cnt_r <= 7'h00;
      end else if (sck && !sck_r) begin
         rise_cnt_r <= rise_cnt_r + 7'h01;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // frame shape as seen on the wire
   frame_length_a: assert property (
      $rose(frame_select_n) |-> rise_cnt_r == 7'h28)
      else $error("frame did not carry forty clock rises");
   idle_clock_a: assert property (
      frame_select_n |-> sck)
      else $error("link clock low outside a frame");
   framed_rise_a: assert property (
      $rose(sck) |-> !frame_select_n)
      else $error("link clock rose without select");
   lead_time_a: assert property (
      $fell(frame_select_n) |-> sck [*4] ##1 !sck)
      else $error("select lead time wrong");
   low_phase_a: assert property (
      $fell(sck) |-> (!sck) [*4] ##1 sck)
      else $error("link clock low phase not four cycles");
   select_gap_a: assert property (
      $rose(frame_select_n) |-> frame_select_n [*8])
      else $error("select high gap too short");
   // both data lines must settle before the sampling side looks at them
   sdi_hold_a: assert property (
      $rose(sck) |=> $stable(sdi) [*3])
      else $error("command data moved while clock high");
   sdo_hold_a: assert property (
      $rose(sck) |-> ##2 $stable(sdo) [*2])
      else $error("response data moved while clock high");
endmodule

// ===== tb/spi_register_datagram_port_test.sv
// self-checking bench: controller and device joined over the serial link
`timescale 1ns/1ps
module spi_register_datagram_port_test;
   import srdp_pkg::*;
   logic        clk;
   logic        reset;
   logic [4:0]  avs_address;
   logic        avs_read;
   logic        avs_write;
   logic [31:0] avs_writedata;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic [31:0] ax1;
   logic [31:0] ax2;
   logic [1:0]  drv_err;
   logic [31:0] reg_rdata;
   logic [31:0] reg_wdata;
   logic [6:0]  reg_addr;
   logic        reg_wr;
   logic        reg_rd;
   logic [7:0]  link_status;
   logic [31:0] mem [0:127];
   logic [31:0] q;
   int          fails;
   int          checks;
   int          n_wr;
   int          n_rd;

   ////////////////////////////////////////////////////////////////////////
   // the two ends face each other; the checker watches the wire
   srdp_link_if srdp_link_if_i ();
   srdp_host srdp_host_i (.CLK(clk), .RESET(reset), .LINK(srdp_link_if_i),
      .AVS_ADDRESS(avs_address), .AVS_READ(avs_read),
      .AVS_WRITE(avs_write), .AVS_WRITEDATA(avs_writedata),
      .AVS_READDATA(avs_readdata), .AVS_WAITREQUEST(avs_waitrequest));
   srdp_device srdp_device_i (.CLK(clk), .RESET(reset),
      .LINK(srdp_link_if_i), .AXIS1_PROFILE_STATE(ax1),
      .AXIS2_PROFILE_STATE(ax2), .DRV_ERR_SET(drv_err),
      .REG_RDATA(reg_rdata), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
      .REG_WR(reg_wr), .REG_RD(reg_rd), .LINK_STATUS(link_status));
   srdp_link_properties srdp_link_properties_i (.CLK(clk), .RESET(reset),
      .sck(srdp_link_if_i.sck), .sdi(srdp_link_if_i.sdi),
      .sdo(srdp_link_if_i.sdo),
      .frame_select_n(srdp_link_if_i.frame_select_n));

   // clock generator, 100 ns period
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   // register file behind the device; read path combinational by contract
   assign reg_rdata = mem[reg_addr];
   always @(posedge clk) begin
      if (reg_wr) begin
         mem[reg_addr] <= reg_wdata;
         n_wr++;
      end
      if (reg_rd) begin
         n_rd++;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         fails++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic results;
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // one bus cycle; request held until waitrequest is sampled low
   task automatic bus(input logic wr, input logic [4:0] a,
                      input logic [31:0] d, output logic [31:0] r);
      int n;
      n = 0;
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= ~wr;
      do begin
         @(posedge clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 20);
      r = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      if (n >= 20) begin
         fails++;
      end
      // one idle edge so a released strobe is never raised in the same step
      @(posedge clk);
   endtask

   // one 40-bit exchange, then compare the status byte and, when chk is set, the returned word
   task automatic frame(input logic wr, input logic [6:0] a,
                        input logic [31:0] d, input logic [7:0] st,
                        input logic [31:0] dat, input logic chk);
      int n;
      bus(1'b1, OFS_CMD_ADDR, {25'h000_0000, a}, q);
      bus(1'b1, OFS_CMD_DATA, d, q);
      bus(1'b1, OFS_CTRL, {30'h0000_0000, wr, 1'b1}, q);
      n = 0;
      do begin
         bus(1'b0, OFS_CTRL, 32'h0000_0000, q);
         n++;
      end while (q[0] !== 1'b0 && n < 500);
      // a frame that never finishes is a failure, not a silent pass
      if (n >= 500) begin
         fails++;
      end
      bus(1'b0, OFS_RSP_STAT, 32'h0000_0000, q);
      check(32'(q[7:0]), 32'(st));
      bus(1'b0, OFS_RSP_DATA, 32'h0000_0000, q);
      if (chk) begin
         check(q, dat);
      end
   endtask

   ////////////////////////////////////////////////////////////////////////
   // main sequence: pipelined reads, writes, flag clearing
   initial begin
      reset = 1'b1;
      avs_address = 5'h00;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0000_0000;
      ax1 = 32'h0000_0000;
      ax2 = 32'h0000_0000;
      drv_err = 2'b00;
      for (int i = 0; i < 128; i++) begin
         mem[i] = 32'h0000_0000;
      end
      mem[7'h21] = 32'h1234_5678;
      repeat (20) @(posedge clk);
      reset <= 1'b0;
      repeat (3) @(posedge clk);
      check(32'(link_status), 32'h0000_0001);
      ax1 <= 32'h0000_0101;
      frame(1'b0, 7'h21, 32'h0000_0000, 8'h29, 32'h0, 1'b0);
      ax2 <= 32'h0000_0101;
      frame(1'b1, 7'h22, 32'h00AB_CDEF, 8'h79, 32'h1234_5678, 1'b1);
      check(mem[7'h22], 32'h00AB_CDEF);
      drv_err <= 2'b11;
      @(posedge clk);
      drv_err <= 2'b00;
      frame(1'b0, GSTATE_ADDR, 32'hFFFF_FFFF, 8'h7F, 32'h00AB_CDEF,
            1'b1);
      frame(1'b0, 7'h21, 32'h0000_0000, 8'h78, 32'h0000_0007, 1'b1);
      ax1 <= 32'h0000_0000;
      frame(1'b1, 7'h30, 32'h8000_0001, 8'h50, 32'h1234_5678, 1'b1);
      check(mem[7'h21], 32'h1234_5678);
      check(mem[7'h30], 32'h8000_0001);
      check(32'(n_wr), 32'h0000_0002);
      check(32'(n_rd), 32'h0000_0002);
      check(32'(link_status), 32'h0000_0050);
      bus(1'b0, 5'h14, 32'h0000_0000, q);
      check(q, 32'h0000_0000);
      results;
   end

   // watchdog: five frames with polling need well under this span
   initial begin
      repeat (30000) @(posedge clk);
      fails++;
      results;
   end
endmodule
